/* logic/display_power_control_regs.sv */
// Control register bank for the display supply regulators and core regulator.
// Assumes a single-clock plain register port; read data appear one cycle after
// the read strobe. Outputs are levels that steer analog cells and a clock gate.
//
// Functional notes
// - Booster clock gate resets to 0; when 1 the divided clock reaches the booster.
// - Core register bit 5, reset 0, puts core and oscillator regulators in protection.
// - Supply register 0 bit 9 requests doubler bypass short, reset 0.
// - Bypass short output is on only when bypass bit is 1 and doubler off.
// - Supply register 0 bit 8 enables the doubler, reset 0.
// - Supply register 0 bits 7..4 hold reference contrast, reset 0x7.
// - Supply register 0 bit 2 puts the reference regulator in protection, reset 0.
// - Supply register 0 bit 1 selects lower (0) or higher (1) reference, reset 0.
// - Supply register 0 bit 0 enables the reference regulator, reset 0.
// - Supply register 1 bits 15..12 hold high-voltage contrast, reset 0x5.
// - Supply register 1 bits 11..10 select drive range 15/12/9 V, reset 0.
// - Supply register 1 bit 9 puts the high-voltage regulator in protection.
// - Supply register 1 bit 8 enables the high-voltage regulator, reset 0.
// - Supply register 1 bit 0 enables booster, bit 1 pulls its output down.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module display_power_control_regs
    import display_power_pkg::*;
#(
    parameter int ADDR_W = 16,
    parameter int DATA_W = 16
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [DATA_W-1:0] RDATA,
    output logic BOOSTER_CLOCK_GATE,
    output logic CORE_HEAVY_LOAD_PROTECT,
    output logic DOUBLER_BYPASS_SHORT,
    output logic DOUBLER_ENABLE,
    output logic [3:0] REFERENCE_CONTRAST_LEVEL,
    output logic REFERENCE_HEAVY_LOAD_PROTECT,
    output logic REFERENCE_LEVEL_SELECT,
    output logic REFERENCE_REGULATOR_ENABLE,
    output logic [3:0] HIGH_VOLTAGE_CONTRAST_LEVEL,
    output logic [1:0] DRIVE_RANGE_SELECT,
    output logic HIGH_VOLTAGE_HEAVY_LOAD_PROTECT,
    output logic HIGH_VOLTAGE_REGULATOR_ENABLE,
    output logic BOOSTER_PULLDOWN,
    output logic BOOSTER_ENABLE
);

    if (ADDR_W < REG_W) begin : g_addr_check
        $error("ADDR_W must be at least 16");
    end
    if (DATA_W < REG_W) begin : g_data_check
        $error("DATA_W must be at least 16");
    end

    typedef struct packed {
        logic booster_clock_gate;
        logic core_heavy_load_protect;
        logic doubler_bypass_short;
        logic doubler_enable;
        logic [3:0] reference_contrast_level;
        logic reference_heavy_load_protect;
        logic reference_level_select;
        logic reference_regulator_enable;
        logic [3:0] high_voltage_contrast_level;
        logic [1:0] drive_range_select;
        logic high_voltage_heavy_load_protect;
        logic high_voltage_regulator_enable;
        logic booster_pulldown;
        logic booster_enable;
        logic bypass_active;
        logic [DATA_W-1:0] rdata;
    } state_t;

    localparam state_t ST_RESET = '{
        booster_clock_gate: RST_BIT,
        core_heavy_load_protect: RST_BIT,
        doubler_bypass_short: RST_BIT,
        doubler_enable: RST_BIT,
        reference_contrast_level: RST_REF_CONTRAST,
        reference_heavy_load_protect: RST_BIT,
        reference_level_select: RST_BIT,
        reference_regulator_enable: RST_BIT,
        high_voltage_contrast_level: RST_HV_CONTRAST,
        drive_range_select: RANGE_15V,
        high_voltage_heavy_load_protect: RST_BIT,
        high_voltage_regulator_enable: RST_BIT,
        booster_pulldown: RST_BIT,
        booster_enable: RST_BIT,
        bypass_active: RST_BIT,
        rdata: '0
    };

    state_t st_ff;
    state_t nxt_st;

    // True when the bus address selects the given register
    function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [15:0] reg_addr);
        addr_hit = (a == ADDR_W'(reg_addr));
    endfunction

    // Read-back word; unlisted bits stay zero
    function automatic logic [REG_W-1:0] read_word(input logic [ADDR_W-1:0] a,
                                                   input state_t s);
        logic [REG_W-1:0] w;
        w = RST_WORD;
        if (addr_hit(a, ADDR_BOOSTER_CLOCK)) begin
            w[BIT_BOOSTER_CLOCK_GATE] = s.booster_clock_gate;
        end else if (addr_hit(a, ADDR_CORE_REG)) begin
            w[BIT_CORE_HEAVY_LOAD] = s.core_heavy_load_protect;
        end else if (addr_hit(a, ADDR_SUPPLY0)) begin
            w[BIT_DOUBLER_BYPASS] = s.doubler_bypass_short;
            w[BIT_DOUBLER_ENABLE] = s.doubler_enable;
            w[REF_CONTRAST_MSB:REF_CONTRAST_LSB] = s.reference_contrast_level;
            w[BIT_REF_HEAVY_LOAD] = s.reference_heavy_load_protect;
            w[BIT_REF_SELECT] = s.reference_level_select;
            w[BIT_REF_ENABLE] = s.reference_regulator_enable;
        end else if (addr_hit(a, ADDR_SUPPLY1)) begin
            w[HV_CONTRAST_MSB:HV_CONTRAST_LSB] = s.high_voltage_contrast_level;
            w[RANGE_MSB:RANGE_LSB] = s.drive_range_select;
            w[BIT_HV_HEAVY_LOAD] = s.high_voltage_heavy_load_protect;
            w[BIT_HV_ENABLE] = s.high_voltage_regulator_enable;
            w[BIT_BOOSTER_PULLDOWN] = s.booster_pulldown;
            w[BIT_BOOSTER_ENABLE] = s.booster_enable;
        end
        read_word = w;
    endfunction

    always_comb begin
        nxt_st = st_ff;
        nxt_st.rdata = '0;
        if (WR && addr_hit(ADDR, ADDR_BOOSTER_CLOCK)) begin
            nxt_st.booster_clock_gate = WDATA[BIT_BOOSTER_CLOCK_GATE];
        end
        if (WR && addr_hit(ADDR, ADDR_CORE_REG)) begin
            nxt_st.core_heavy_load_protect = WDATA[BIT_CORE_HEAVY_LOAD];
        end
        if (WR && addr_hit(ADDR, ADDR_SUPPLY0)) begin
            nxt_st.doubler_bypass_short = WDATA[BIT_DOUBLER_BYPASS];
            nxt_st.doubler_enable = WDATA[BIT_DOUBLER_ENABLE];
            nxt_st.reference_contrast_level = WDATA[REF_CONTRAST_MSB:REF_CONTRAST_LSB];
            nxt_st.reference_heavy_load_protect = WDATA[BIT_REF_HEAVY_LOAD];
            nxt_st.reference_level_select = WDATA[BIT_REF_SELECT];
            nxt_st.reference_regulator_enable = WDATA[BIT_REF_ENABLE];
        end
        if (WR && addr_hit(ADDR, ADDR_SUPPLY1)) begin
            nxt_st.high_voltage_contrast_level = WDATA[HV_CONTRAST_MSB:HV_CONTRAST_LSB];
            nxt_st.drive_range_select = WDATA[RANGE_MSB:RANGE_LSB];
            nxt_st.high_voltage_heavy_load_protect = WDATA[BIT_HV_HEAVY_LOAD];
            nxt_st.high_voltage_regulator_enable = WDATA[BIT_HV_ENABLE];
            nxt_st.booster_pulldown = WDATA[BIT_BOOSTER_PULLDOWN];
            nxt_st.booster_enable = WDATA[BIT_BOOSTER_ENABLE];
        end
        // Running doubler overrides the bypass request
        nxt_st.bypass_active = nxt_st.doubler_bypass_short && !nxt_st.doubler_enable;
        if (RD) begin
            nxt_st.rdata = DATA_W'(read_word(ADDR, st_ff));
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            st_ff <= ST_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign RDATA = st_ff.rdata;
    assign BOOSTER_CLOCK_GATE = st_ff.booster_clock_gate;
    assign CORE_HEAVY_LOAD_PROTECT = st_ff.core_heavy_load_protect;
    assign DOUBLER_BYPASS_SHORT = st_ff.bypass_active;
    assign DOUBLER_ENABLE = st_ff.doubler_enable;
    assign REFERENCE_CONTRAST_LEVEL = st_ff.reference_contrast_level;
    assign REFERENCE_HEAVY_LOAD_PROTECT = st_ff.reference_heavy_load_protect;
    assign REFERENCE_LEVEL_SELECT = st_ff.reference_level_select;
    assign REFERENCE_REGULATOR_ENABLE = st_ff.reference_regulator_enable;
    assign HIGH_VOLTAGE_CONTRAST_LEVEL = st_ff.high_voltage_contrast_level;
    assign DRIVE_RANGE_SELECT = st_ff.drive_range_select;
    assign HIGH_VOLTAGE_HEAVY_LOAD_PROTECT = st_ff.high_voltage_heavy_load_protect;
    assign HIGH_VOLTAGE_REGULATOR_ENABLE = st_ff.high_voltage_regulator_enable;
    assign BOOSTER_PULLDOWN = st_ff.booster_pulldown;
    assign BOOSTER_ENABLE = st_ff.booster_enable;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    sequence s_wr_bclk;
        WR && addr_hit(ADDR, ADDR_BOOSTER_CLOCK);
    endsequence
    sequence s_wr_core;
        WR && addr_hit(ADDR, ADDR_CORE_REG);
    endsequence
    sequence s_wr_sup0;
        WR && addr_hit(ADDR, ADDR_SUPPLY0);
    endsequence
    sequence s_wr_sup1;
        WR && addr_hit(ADDR, ADDR_SUPPLY1);
    endsequence
    sequence s_rd_sup0;
        RD && addr_hit(ADDR, ADDR_SUPPLY0);
    endsequence
    sequence s_rd_sup1;
        RD && addr_hit(ADDR, ADDR_SUPPLY1);
    endsequence

    // Reset values seen in the cycle after a reset
    AST_RESET_VALUES: assert property (disable iff (1'b0)
        !RST_N |=> (REFERENCE_CONTRAST_LEVEL == RST_REF_CONTRAST)
            && (HIGH_VOLTAGE_CONTRAST_LEVEL == RST_HV_CONTRAST)
            && (DRIVE_RANGE_SELECT == RANGE_15V) && !BOOSTER_CLOCK_GATE
            && !CORE_HEAVY_LOAD_PROTECT && !DOUBLER_ENABLE && !DOUBLER_BYPASS_SHORT
            && !REFERENCE_REGULATOR_ENABLE && !BOOSTER_ENABLE && !BOOSTER_PULLDOWN
            && !HIGH_VOLTAGE_REGULATOR_ENABLE && (RDATA == '0))
        else $error("reset values wrong");

    AST_BCLK_GATE_WRITE: assert property (
        s_wr_bclk |=> BOOSTER_CLOCK_GATE == $past(WDATA[BIT_BOOSTER_CLOCK_GATE]))
        else $error("booster clock gate not written");

    AST_CORE_PROTECT_WRITE: assert property (
        s_wr_core |=> CORE_HEAVY_LOAD_PROTECT == $past(WDATA[BIT_CORE_HEAVY_LOAD]))
        else $error("core protection bit not written");

    AST_BYPASS_GATED: assert property (
        DOUBLER_BYPASS_SHORT == (st_ff.doubler_bypass_short && !DOUBLER_ENABLE))
        else $error("bypass short active while doubler runs");

    AST_BYPASS_WRITE: assert property (
        s_wr_sup0 ##1 !DOUBLER_ENABLE |-> DOUBLER_BYPASS_SHORT == $past(WDATA[BIT_DOUBLER_BYPASS]))
        else $error("bypass request not applied");

    AST_SUP0_FIELDS: assert property (
        s_wr_sup0 |=> (DOUBLER_ENABLE == $past(WDATA[BIT_DOUBLER_ENABLE]))
            && (REFERENCE_CONTRAST_LEVEL == $past(WDATA[REF_CONTRAST_MSB:REF_CONTRAST_LSB]))
            && (REFERENCE_HEAVY_LOAD_PROTECT == $past(WDATA[BIT_REF_HEAVY_LOAD]))
            && (REFERENCE_LEVEL_SELECT == $past(WDATA[BIT_REF_SELECT]))
            && (REFERENCE_REGULATOR_ENABLE == $past(WDATA[BIT_REF_ENABLE])))
        else $error("supply register 0 fields not written");

    AST_SUP1_FIELDS: assert property (
        s_wr_sup1 |=> (HIGH_VOLTAGE_CONTRAST_LEVEL == $past(WDATA[HV_CONTRAST_MSB:HV_CONTRAST_LSB]))
            && (DRIVE_RANGE_SELECT == $past(WDATA[RANGE_MSB:RANGE_LSB]))
            && (HIGH_VOLTAGE_HEAVY_LOAD_PROTECT == $past(WDATA[BIT_HV_HEAVY_LOAD])))
        else $error("supply register 1 fields not written");

    AST_HV_BOOSTER_WRITE: assert property (
        s_wr_sup1 |=> (HIGH_VOLTAGE_REGULATOR_ENABLE == $past(WDATA[BIT_HV_ENABLE]))
            && (BOOSTER_PULLDOWN == $past(WDATA[BIT_BOOSTER_PULLDOWN]))
            && (BOOSTER_ENABLE == $past(WDATA[BIT_BOOSTER_ENABLE])))
        else $error("booster or high voltage enable not written");

    // Sampled reset in the antecedent keeps the edge that applies a reset out of this check
    AST_HOLD_NO_WRITE: assert property (
        RST_N && !WR |=> $stable(HIGH_VOLTAGE_REGULATOR_ENABLE) && $stable(BOOSTER_ENABLE)
            && $stable(REFERENCE_CONTRAST_LEVEL) && $stable(BOOSTER_CLOCK_GATE)
            && $stable(CORE_HEAVY_LOAD_PROTECT) && $stable(DOUBLER_ENABLE))
        else $error("control changed without a write");

    AST_RD_SUP0_RESERVED: assert property (
        s_rd_sup0 |=> (RDATA[REG_W-1:BIT_DOUBLER_BYPASS+1] == '0)
            && (RDATA[REF_CONTRAST_LSB-1] == 1'b0)
            && (RDATA[REF_CONTRAST_MSB:REF_CONTRAST_LSB] == REFERENCE_CONTRAST_LEVEL))
        else $error("supply register 0 readback wrong");

    AST_RD_SUP1_RESERVED: assert property (
        s_rd_sup1 |=> (RDATA[BIT_HV_ENABLE-1:BIT_BOOSTER_PULLDOWN+1] == '0)
            && (RDATA[RANGE_MSB:RANGE_LSB] == DRIVE_RANGE_SELECT)
            && (RDATA[BIT_BOOSTER_ENABLE] == BOOSTER_ENABLE))
        else $error("supply register 1 readback wrong");

    AST_RDATA_ONE_CYCLE: assert property (
        !RD |=> RDATA == '0)
        else $error("read data stand outside the read cycle");

endmodule

`default_nettype wire

/* logic/display_power_pkg.sv */
// Package for the display supply and core regulator control register bank.
// Assumes a 16-bit address space with registers at their printed byte offsets.
package display_power_pkg;

    // Register addresses
    localparam logic [15:0] ADDR_BOOSTER_CLOCK = 16'h5072;
    localparam logic [15:0] ADDR_CORE_REG = 16'h5120;
    localparam logic [15:0] ADDR_SUPPLY0 = 16'h5600;
    localparam logic [15:0] ADDR_SUPPLY1 = 16'h5602;

    // Booster clock register fields
    localparam int BIT_BOOSTER_CLOCK_GATE = 0;

    // Core regulator register fields
    localparam int BIT_CORE_HEAVY_LOAD = 5;

    // Display supply register 0 fields
    localparam int BIT_DOUBLER_BYPASS = 9;
    localparam int BIT_DOUBLER_ENABLE = 8;
    localparam int REF_CONTRAST_LSB = 4;
    localparam int REF_CONTRAST_MSB = 7;
    localparam int BIT_REF_HEAVY_LOAD = 2;
    localparam int BIT_REF_SELECT = 1;
    localparam int BIT_REF_ENABLE = 0;

    // Display supply register 1 fields
    localparam int HV_CONTRAST_LSB = 12;
    localparam int HV_CONTRAST_MSB = 15;
    localparam int RANGE_LSB = 10;
    localparam int RANGE_MSB = 11;
    localparam int BIT_HV_HEAVY_LOAD = 9;
    localparam int BIT_HV_ENABLE = 8;
    localparam int BIT_BOOSTER_PULLDOWN = 1;
    localparam int BIT_BOOSTER_ENABLE = 0;

    // Width of every register word
    localparam int REG_W = 16;

    // Reset values
    localparam logic RST_BIT = 1'b0;
    localparam logic [3:0] RST_REF_CONTRAST = 4'h7;
    localparam logic [3:0] RST_HV_CONTRAST = 4'h5;
    localparam logic [15:0] RST_WORD = 16'h0000;

    // Drive range codes
    localparam logic [1:0] RANGE_15V = 2'h0;
    localparam logic [1:0] RANGE_12V = 2'h1;
    localparam logic [1:0] RANGE_9V = 2'h2;
    localparam logic [1:0] RANGE_RESERVED = 2'h3;

endpackage

/* dv/tb_display_power_control_regs.sv */
// Self-checking testbench for the display supply control register bank.
// Assumes the plain register port of the bank and a 20 MHz clock; the bench keeps
// shadow copies of the registers and predicts every read and every control output.
`timescale 1ns/1ps
`default_nettype none

module tb_display_power_control_regs;
    import display_power_pkg::*;

    logic CLK;
    logic RST_N;
    logic [15:0] ADDR;
    logic [15:0] WDATA;
    logic WR;
    logic RD;
    wire logic [15:0] RDATA;
    wire logic [20:0] ctl;
    wire logic bcg, core, byp, dben, rhl, rsel, ren, hvhl, hven, pull, bst;
    wire logic [3:0] rcon, hvcon;
    wire logic [1:0] rng;
    int err_count;
    int num_checks;
    logic [15:0] sh_bclk, sh_core, sh_s0, sh_s1;

    assign ctl = {bcg, core, byp, dben, rcon, rhl, rsel, ren, hvcon, rng, hvhl, hven, pull, bst};

    display_power_control_regs u_dut (
        .CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .BOOSTER_CLOCK_GATE(bcg), .CORE_HEAVY_LOAD_PROTECT(core),
        .DOUBLER_BYPASS_SHORT(byp), .DOUBLER_ENABLE(dben), .REFERENCE_CONTRAST_LEVEL(rcon),
        .REFERENCE_HEAVY_LOAD_PROTECT(rhl), .REFERENCE_LEVEL_SELECT(rsel),
        .REFERENCE_REGULATOR_ENABLE(ren), .HIGH_VOLTAGE_CONTRAST_LEVEL(hvcon),
        .DRIVE_RANGE_SELECT(rng), .HIGH_VOLTAGE_HEAVY_LOAD_PROTECT(hvhl),
        .HIGH_VOLTAGE_REGULATOR_ENABLE(hven), .BOOSTER_PULLDOWN(pull), .BOOSTER_ENABLE(bst)
    );

    initial begin
        CLK = 1'b0;
        forever #25 CLK = ~CLK;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("Checks made %0d, mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    function automatic logic [20:0] exp_ctl();
        return {sh_bclk[0], sh_core[5], sh_s0[9] & ~sh_s0[8], sh_s0[8], sh_s0[7:4], sh_s0[2],
                sh_s0[1], sh_s0[0], sh_s1[15:12], sh_s1[11:10], sh_s1[9], sh_s1[8], sh_s1[1:0]};
    endfunction

    task automatic shadow_reset();
        sh_bclk = 16'h0000;
        sh_core = 16'h0000;
        sh_s0 = 16'h0070;
        sh_s1 = 16'h5000;
    endtask

    task automatic bus_write(input logic [15:0] a, input logic [15:0] d);
        @(posedge CLK);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge CLK);
        WR <= 1'b0;
        #1;
        if (a === 16'h5072) sh_bclk = d & 16'h0001;
        if (a === 16'h5120) sh_core = d & 16'h0020;
        if (a === 16'h5600) sh_s0 = d & 16'h03F7;
        if (a === 16'h5602) sh_s1 = d & 16'hFF03;
    endtask

    task automatic rd_check(input logic [15:0] a, input logic [15:0] exp);
        @(posedge CLK);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge CLK);
        RD <= 1'b0;
        #1;
        check("rdata", {16'h0000, RDATA}, {16'h0000, exp});
    endtask

    task automatic verify_all();
        rd_check(16'h5072, sh_bclk);
        rd_check(16'h5120, sh_core);
        rd_check(16'h5600, sh_s0);
        rd_check(16'h5602, sh_s1);
        check("outputs", {11'h000, ctl}, {11'h000, exp_ctl()});
    endtask

    task automatic test_reset();
        check("outputs", {11'h000, ctl},
              {11'h000, 4'h0, RST_REF_CONTRAST, 3'h0, RST_HV_CONTRAST, 6'h00});
        verify_all();
        rd_check(16'h5604, 16'h0000);
        $display("test reset done");
    endtask

    task automatic test_all_ones();
        bus_write(16'h5072, 16'hFFFF);
        bus_write(16'h5120, 16'hFFFF);
        bus_write(16'h5600, 16'hFEFF);
        bus_write(16'h5602, 16'hFFFF);
        verify_all();
        bus_write(16'h5600, 16'h0000);
        bus_write(16'h5602, 16'h0000);
        bus_write(16'h5120, 16'h0000);
        bus_write(16'h5072, 16'h0000);
        verify_all();
        $display("test all ones done");
    endtask

    task automatic test_bypass();
        logic [15:0] seq [4] = '{16'h0200, 16'h0300, 16'h0100, 16'h0206};
        foreach (seq[i]) begin
            bus_write(16'h5600, seq[i]);
            check("bypass", {31'h0, byp}, {31'h0, seq[i][9] & ~seq[i][8]});
            verify_all();
        end
        $display("test bypass done");
    endtask

    task automatic test_fields();
        for (int i = 0; i < 4; i++) begin
            bus_write(16'h5602, {i[0] ? 4'hF : 4'h0, i[1:0], 10'h101});
            check("range", {30'h0, rng}, i);
            bus_write(16'h5600, {8'h00, i[0] ? 4'h0 : 4'hF, 1'b0, i[1], 2'b01});
            verify_all();
        end
        $display("test fields done");
    endtask

    task automatic test_unmapped();
        bus_write(16'h5604, 16'hFFFF);
        bus_write(16'h5121, 16'hFFFF);
        bus_write(16'hD600, 16'hFFFF);
        bus_write(16'h5073, 16'hFFFF);
        verify_all();
        rd_check(16'hD602, 16'h0000);
        $display("test unmapped done");
    endtask

    task automatic test_back_to_back();
        @(posedge CLK);
        WR <= 1'b1;
        ADDR <= 16'h5120;
        WDATA <= 16'h0020;
        @(posedge CLK);
        WR <= 1'b0;
        RD <= 1'b1;
        sh_core = 16'h0020;
        @(posedge CLK);
        RD <= 1'b0;
        #1;
        check("b2b rdata", {16'h0000, RDATA}, 32'h0000_0020);
        check("core protect", {31'h0, core}, 32'h1);
        @(posedge CLK);
        #1;
        check("rdata idle", {16'h0000, RDATA}, 32'h0);
        $display("test back to back done");
    endtask

    task automatic test_mid_reset();
        bus_write(16'h5072, 16'h0001);
        bus_write(16'h5602, 16'h0001);
        bus_write(16'h5602, 16'hA703);
        check("clock gate", {31'h0, bcg}, 32'h1);
        @(posedge CLK);
        RST_N <= 1'b0;
        @(posedge CLK);
        RST_N <= 1'b1;
        shadow_reset();
        verify_all();
        $display("test mid reset done");
    endtask

    initial begin
        RST_N = 1'b0;
        ADDR = 16'h0000;
        WDATA = 16'h0000;
        WR = 1'b0;
        RD = 1'b0;
        err_count = 0;
        num_checks = 0;
        shadow_reset();
        repeat (12) @(posedge CLK);
        RST_N <= 1'b1;
        test_reset();
        test_all_ones();
        test_bypass();
        test_fields();
        test_unmapped();
        test_back_to_back();
        test_mid_reset();
        stop_test();
    end

    initial begin
        repeat (5000) @(posedge CLK);
        err_count++;
        $display("Watchdog expired before the tests ended");
        stop_test();
    end
endmodule

`default_nettype wire
